// [verilog/flash_host_ctrl.v]
// Host controller that drives a parallel flash through its pins
//
// Overview of operation
// RULE_01: Standby floats device data pins.
// RULE_02: CE or OE high floats data pins.
// RULE_03: Device reads array after power-up.
// RULE_04: Device returns to read after completion.
// RULE_05: Suspended sectors read status, others array.
// RULE_06: Host writes reset after timeout or identification.
// RULE_07: Identification codes selected by A1 A0.
// RULE_08: Sector number on top bits for protect check.
// RULE_09: Hold A8 high for maker code.
// RULE_10: Identification by high voltage or command.
// RULE_11: Write needs CE WE low, OE high.
// RULE_12: Address latched on later falling edge.
// RULE_13: Data latched on earlier rising edge.
// RULE_14: Completion found by polling status bits.
// RULE_15: Protected sectors refuse program and erase.
// RULE_16: Stable address brings automatic sleep.
// RULE_17: Supply lockout ignores writes and resets.
// RULE_18: Short strobe glitches start no write.
// RULE_19: All strobes low counts as read.
// RULE_20: Power-up locks out writes.
// RULE_21: Unlock cycles precede program or erase.
// RULE_22: Two unlocks then identification command.
// RULE_23: Bad sequence returns device to read.
// RULE_24: Identification reads return codes until exit.
`timescale 1ns/1ns
`include "flash_ctrl_consts.vh"
module flash_host_ctrl (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Flash pins
    output wire [16:0] fl_addr_o,
    output wire [7:0]  fl_dq_o,
    output wire        fl_dq_oe_o,
    input  wire [7:0]  fl_dq_i,
    output wire        fl_ce_n_o,
    output wire        fl_oe_n_o,
    output wire        fl_we_n_o
);
    // ***********************************
    // Sequencer states
    // ***********************************
    localparam Q_IDLE  = 3'd0;
    localparam Q_ISSUE = 3'd1;
    localparam Q_WAIT  = 3'd2;
    localparam Q_POLL  = 3'd3;
    localparam Q_POLL2 = 3'd4;

    reg  [2:0]  state;        // Sequencer state
    reg  [2:0]  op;           // Operation in progress
    reg  [2:0]  step;         // Index of bus cycle within sequence
    reg  [16:0] addr;         // Target flash address register
    reg  [7:0]  wdata;        // Write data register
    reg  [7:0]  rdata;        // Last byte read
    reg         busy;         // Sequence running
    reg         timeout;      // Sticky timeout flag seen while polling
    reg         done;         // Sticky completion flag
    reg  [7:0]  prev_rd;      // Previous poll byte for toggle compare
    reg         start;        // Pulse to the cycle engine
    reg         cyc_wr;       // Direction to the cycle engine
    reg  [16:0] cyc_addr;     // Address to the cycle engine
    reg  [7:0]  cyc_data;     // Data to the cycle engine
    wire        cyc_done;     // Engine finished a cycle
    wire [7:0]  cyc_rdata;    // Engine read byte
    reg  [2:0]  last_step;    // Final step index for the running op
    reg  [16:0] next_addr;    // Address for the current step
    reg  [7:0]  next_data;    // Data for the current step
    reg         next_wr;      // Direction for the current step

    // Number of bus cycles per operation
    function [2:0] op_len;
        input [2:0] o;
        begin
            case (o)
                `OP_AUTOSEL: op_len = 3'd3;   // Unlock, unlock, command RULE_22 RULE_10
                `OP_PROGRAM: op_len = 3'd4;   // Unlock pair, setup, data RULE_21
                default:     op_len = 3'd1;
            endcase
        end
    endfunction

    // ***********************************
    // Per-step address and data of a command sequence
    // ***********************************
    always @* begin
        // Raw writes pass straight through; a broken sequence parks the device RULE_23
        next_wr   = 1'b1;
        next_addr = addr;
        next_data = wdata;
        last_step = op_len(op) - 3'd1;
        if (op == `OP_AUTOSEL || op == `OP_PROGRAM) begin
            case (step)
                3'd0: begin
                    next_addr = `UNLOCK_ADDR1;
                    next_data = `UNLOCK_DATA1;
                end
                3'd1: begin
                    next_addr = `UNLOCK_ADDR2;
                    next_data = `UNLOCK_DATA2;
                end
                3'd2: begin
                    next_addr = `UNLOCK_ADDR1;
                    next_data = (op == `OP_AUTOSEL) ? `CMD_AUTOSEL : `CMD_PROGRAM;
                end
                default: begin
                    next_addr = addr;
                    next_data = wdata;
                end
            endcase
        end else if (op == `OP_RESET) begin
            next_data = `CMD_RESET;       // Leave timeout or identification RULE_06
        end else if (op == `OP_READ || op == `OP_POLL) begin
            // Identification reads use addr with A1 A0 and A8 set by software
            // Sector number rides on the top address bits for protect checks
            next_wr = 1'b0;               // RULE_07 RULE_09 RULE_24 RULE_08
        end
    end

    // ***********************************
    // Wishbone registers and sequencer
    // ***********************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            // No command after reset: the device is left in array read
            state    <= Q_IDLE;   // RULE_03 RULE_17 RULE_20
            op       <= 3'h0;
            step     <= 3'h0;
            addr     <= 17'h0_0000;
            wdata    <= 8'h00;
            rdata    <= 8'h00;
            busy     <= 1'b0;
            timeout  <= 1'b0;
            done     <= 1'b0;
            prev_rd  <= 8'h00;
            start    <= 1'b0;
            cyc_wr   <= 1'b0;
            cyc_addr <= 17'h0_0000;
            cyc_data <= 8'h00;
            wb_ack_o <= 1'b0;
            wb_dat_o <= `RESET_DATA;
        end else begin
            start    <= 1'b0;
            wb_ack_o <= 1'b0;
            // Register access, one wait state, ack drops next cycle
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= 32'h0000_0000;
                if (wb_we_i) begin
                    case (wb_adr_i)
                        `REG_ADDR:  if (wb_sel_i[0]) addr <= wb_dat_i[16:0];
                        `REG_WDATA: if (wb_sel_i[0]) wdata <= wb_dat_i[7:0];
                        `REG_CTRL: begin
                            // New orders only when idle; busy refuses them
                            if (wb_sel_i[0] && !busy && wb_dat_i[2:0] != 3'h0) begin
                                op    <= wb_dat_i[2:0];
                                step  <= 3'h0;
                                busy  <= 1'b1;
                                state <= Q_ISSUE;
                                if (wb_dat_i[2:0] == `OP_POLL) begin
                                    done    <= 1'b0;
                                    timeout <= 1'b0;
                                end
                            end
                        end
                        default: ;
                    endcase
                end else begin
                    case (wb_adr_i)
                        `REG_CTRL:   wb_dat_o <= {29'h0, op};
                        `REG_ADDR:   wb_dat_o <= {15'h0, addr};
                        `REG_WDATA:  wb_dat_o <= {24'h0, wdata};
                        `REG_STATUS: wb_dat_o <= {16'h0, rdata, 5'h0,
                                                  done, timeout, busy};
                        default:     wb_dat_o <= 32'h0000_0000;
                    endcase
                end
            end
            case (state)
                Q_IDLE: ;
                Q_ISSUE: begin
                    start    <= 1'b1;
                    cyc_wr   <= next_wr;
                    cyc_addr <= next_addr;
                    cyc_data <= next_data;
                    state    <= Q_WAIT;
                end
                Q_WAIT: begin
                    if (cyc_done) begin
                        rdata <= cyc_rdata;
                        if (op == `OP_POLL) begin
                            prev_rd <= cyc_rdata;
                            state   <= Q_POLL;
                        end else if (step == last_step) begin
                            busy  <= 1'b0;
                            done  <= 1'b1;
                            state <= Q_IDLE;
                        end else begin
                            step  <= step + 3'd1;
                            state <= Q_ISSUE;
                        end
                    end
                end
                Q_POLL: begin
                    // Second read for the toggle compare; status reads also
                    // cover suspended sectors RULE_14 RULE_05
                    start    <= 1'b1;
                    cyc_wr   <= 1'b0;
                    cyc_addr <= addr;
                    state    <= Q_POLL2;
                end
                Q_POLL2: begin
                    if (cyc_done) begin
                        rdata <= cyc_rdata;
                        if (cyc_rdata[6] == prev_rd[6]) begin
                            // Toggle stopped: back in read mode, or refused RULE_04 RULE_14
                            // A protected target never toggles at all RULE_15
                            busy  <= 1'b0;
                            done  <= 1'b1;
                            state <= Q_IDLE;
                        end else if (cyc_rdata[5]) begin
                            // Timeout bit high: software must issue reset RULE_06
                            busy    <= 1'b0;
                            timeout <= 1'b1;
                            state   <= Q_IDLE;
                        end else begin
                            prev_rd <= cyc_rdata;
                            state   <= Q_POLL;
                        end
                    end
                end
                default: state <= Q_IDLE;
            endcase
        end
    end

    // ***********************************
    // Pin cycle engine
    // ***********************************
    flash_bus_cycle u_cycle (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .start_i    (start),
        .write_i    (cyc_wr),
        .addr_i     (cyc_addr),
        .wdata_i    (cyc_data),
        .done_o     (cyc_done),
        .rdata_o    (cyc_rdata),
        .fl_addr_o  (fl_addr_o),
        .fl_dq_o    (fl_dq_o),
        .fl_dq_oe_o (fl_dq_oe_o),
        .fl_dq_i    (fl_dq_i),
        .fl_ce_n_o  (fl_ce_n_o),
        .fl_oe_n_o  (fl_oe_n_o),
        .fl_we_n_o  (fl_we_n_o)
    );
endmodule // flash_host_ctrl

// [verilog/flash_ctrl_consts.vh]
// Constants for the parallel flash host controller
`ifndef FLASH_CTRL_CONSTS_VH
`define FLASH_CTRL_CONSTS_VH
// Wishbone register offsets (byte addresses)
`define REG_CTRL        4'h0
`define REG_ADDR        4'h4
`define REG_WDATA       4'h8
`define REG_STATUS      4'hC
// Command field codes in REG_CTRL[2:0]
`define OP_READ         3'h1
`define OP_WRITE        3'h2
`define OP_RESET        3'h3
`define OP_AUTOSEL      3'h4
`define OP_PROGRAM      3'h5
`define OP_POLL         3'h6
// Status bit positions
`define ST_BUSY         0
`define ST_TIMEOUT      1
`define ST_DONE         2
// Unlock sequence values
`define UNLOCK_ADDR1    17'h0_0555
`define UNLOCK_ADDR2    17'h0_02AA
`define UNLOCK_DATA1    8'hAA
`define UNLOCK_DATA2    8'h55
`define CMD_AUTOSEL     8'h90
`define CMD_PROGRAM     8'hA0
`define CMD_RESET       8'hF0
// Identification address offsets
`define ID_MAKER_ADDR   17'h0_0100
`define ID_PART_ADDR    17'h0_0001
// Bus timing: strobe width in ns, cycle counts at 20 ns
`define CLK_NS          20
`define STROBE_NS       70
`define STROBE_CYC      ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_DATA      32'h0000_0000
`endif

// [verilog/flash_bus_cycle.v]
// Single strobe-timed bus cycle engine for the flash pins
`timescale 1ns/1ns
`include "flash_ctrl_consts.vh"
module flash_bus_cycle (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Request
    input  wire        start_i,
    input  wire        write_i,
    input  wire [16:0] addr_i,
    input  wire [7:0]  wdata_i,
    output reg         done_o,
    output reg  [7:0]  rdata_o,
    // Flash pins
    output reg  [16:0] fl_addr_o,
    output reg  [7:0]  fl_dq_o,
    output reg         fl_dq_oe_o,
    input  wire [7:0]  fl_dq_i,
    output reg         fl_ce_n_o,
    output reg         fl_oe_n_o,
    output reg         fl_we_n_o
);
    localparam S_IDLE = 2'd0;
    localparam S_SET  = 2'd1;
    localparam S_HOLD = 2'd2;
    localparam S_END  = 2'd3;
    reg [1:0] state;      // Cycle phase
    reg [3:0] cnt;        // Strobe width counter
    reg [7:0] dq_s1;      // Data pin synchroniser stage 1
    reg [7:0] dq_s2;      // Data pin synchroniser stage 2
    reg       is_wr;      // Current cycle is a write

    // ***********************************
    // Data pins come from outside: two flops
    // ***********************************
    always @(posedge clk_i) begin
        dq_s1 <= fl_dq_i;
        dq_s2 <= dq_s1;
    end

    // ***********************************
    // Strobe sequencing
    // ***********************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            state      <= S_IDLE;
            cnt        <= 4'h0;
            done_o     <= 1'b0;
            rdata_o    <= 8'h00;
            fl_addr_o  <= 17'h0_0000;
            fl_dq_o    <= 8'h00;
            fl_dq_oe_o <= 1'b0;
            fl_ce_n_o  <= 1'b1;   // Standby, device floats its pins RULE_01
            fl_oe_n_o  <= 1'b1;
            fl_we_n_o  <= 1'b1;
            is_wr      <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_i) begin
                        // Address settles before any strobe falls
                        // Held through the cycle so the later fall latches it RULE_12
                        fl_addr_o <= addr_i;  // Steady address lets the device sleep RULE_16
                        fl_dq_o   <= wdata_i;
                        is_wr     <= write_i;
                        state     <= S_SET;
                    end
                end
                S_SET: begin
                    // Write: CE and WE low, OE held high RULE_11
                    // Never all three low, that reads as a read RULE_19
                    fl_ce_n_o  <= 1'b0;
                    fl_we_n_o  <= ~is_wr;
                    fl_oe_n_o  <= is_wr;
                    fl_dq_oe_o <= is_wr;
                    cnt        <= 4'h0;
                    state      <= S_HOLD;
                end
                S_HOLD: begin
                    // Width well above the glitch filter RULE_18
                    if (cnt == `STROBE_CYC + 1) begin
                        fl_we_n_o <= 1'b1;  // Data latched on this rise RULE_13
                        fl_oe_n_o <= 1'b1;  // Device floats its pins RULE_02
                        fl_ce_n_o <= 1'b1;
                        rdata_o   <= dq_s2;
                        state     <= S_END;
                    end else begin
                        cnt <= cnt + 4'h1;
                    end
                end
                S_END: begin
                    // Release data a cycle after the strobes rise for hold time
                    fl_dq_oe_o <= 1'b0;
                    done_o     <= 1'b1;
                    state      <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // flash_bus_cycle

// [verif/flash_host_checker.sv]
// Concurrent checks on the flash host controller ports
`timescale 1ns/1ns
module flash_host_checker (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Wishbone
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    // Flash pins
    input wire [16:0] fl_addr_o,
    input wire [7:0]  fl_dq_o,
    input wire        fl_dq_oe_o,
    input wire        fl_ce_n_o,
    input wire        fl_oe_n_o,
    input wire        fl_we_n_o
);
    // ****************
    // Common timing
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Write strobe only inside a proper write pattern
    property p_wr_strobes; !fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o; endproperty
    a_wr_strobes: assert property (p_wr_strobes) else $error("write strobe misplaced");
    // All three strobes low would read, not write
    property p_no_all_low; !(!fl_ce_n_o && !fl_oe_n_o && !fl_we_n_o); endproperty
    a_no_all_low: assert property (p_no_all_low) else $error("all strobes low");
    // Host never drives data while the device may be driving
    property p_no_fight; fl_dq_oe_o |-> fl_oe_n_o; endproperty
    a_no_fight: assert property (p_no_fight) else $error("data driven with output on");
    // Address held for the whole selected cycle
    property p_addr_hold; !fl_ce_n_o && $past(!fl_ce_n_o) |-> $stable(fl_addr_o); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
    // Write data driven and held while the write strobe is low
    property p_data_hold; !fl_we_n_o && $past(!fl_we_n_o) |-> $stable(fl_dq_o) && fl_dq_oe_o;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("write data moved");
    // Strobes are far wider than any glitch filter
    property p_width; $fell(fl_ce_n_o) |-> !fl_ce_n_o [*4]; endproperty
    a_width: assert property (p_width) else $error("strobe too short");
    // Acknowledge is a single cycle pulse
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    // Every taken request is answered on the next cycle
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
endmodule // flash_host_checker

bind flash_host_ctrl flash_host_checker chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
    .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o)
);

// [verif/flash_dev_model.sv]
// Behavioural model of the byte-wide parallel flash
`timescale 1ns/1ns
module flash_dev_model #(
    parameter [7:0] MAKER = 8'h3a, // Arbitrary value
    parameter [7:0] PART  = 8'h5c, // Arbitrary value
    parameter [7:0] CFG   = 8'h4b, // Arbitrary value
    parameter [7:0] PROT  = 8'h80  // Protected sector map
) (
    // Pins from the host
    input  wire [16:0] addr_i,
    input  wire [7:0]  dq_i,
    input  wire        dq_oe_i,
    input  wire        ce_n_i,
    input  wire        oe_n_i,
    input  wire        we_n_i,
    // Pins to the host
    output wire [7:0]  dq_o
);
    reg  [7:0]  mem [0:15];   // Small array, low address bits only
    reg  [1:0]  st;           // Unlock progress
    reg         idm;          // Identification mode
    reg  [1:0]  busy;         // Reads left until program ends
    reg         tog;          // Toggling status bit
    reg  [16:0] la;           // Latched write address
    reg  [16:0] pa;           // Program address
    reg  [7:0]  pd;           // Program data
    reg  [7:0]  last;         // Last value put out
    reg  [7:0]  val;          // Value on a read
    integer     i;
    wire wr_n = ce_n_i | we_n_i | ~oe_n_i;
    wire rd = ~ce_n_i & ~oe_n_i;

    // Power-up lands in array read with no unlock pending
    initial begin
        for (i = 0; i < 16; i = i + 1) mem[i] = 8'ha0 + i[7:0];
        st = 2'd0;
        idm = 1'b0;
        busy = 2'd0;
        tog = 1'b0;
        last = 8'h00;
    end
    // Read source: status, identifier or array
    always @* begin
        if (busy != 2'd0) val = {~pd[7], tog, 6'h00};
        else if (idm) begin
            case (addr_i[1:0])
                2'd0:    val = addr_i[8] ? MAKER : CFG;
                2'd1:    val = PART;
                2'd2:    val = {7'h00, PROT[addr_i[16:14]]};
                default: val = 8'h00;
            endcase
        end else val = mem[addr_i[3:0]];
    end
    // Released bus shows the inverse of the last value, never a stale copy
    assign dq_o = rd ? val : ~last;
    always @(posedge oe_n_i) last = val;
    // Address on the later falling edge
    always @(negedge wr_n) la = addr_i;
    // Data on the earlier rising edge; command decode
    always @(posedge wr_n) begin
        if (!dq_oe_i) st = 2'd0;
        else if (dq_i == 8'hf0) begin
            st = 2'd0;
            idm = 1'b0;
        end else if (st == 2'd0 && la[11:0] == 12'h555 && dq_i == 8'haa) st = 2'd1;
        else if (st == 2'd1 && la[11:0] == 12'h2aa && dq_i == 8'h55) st = 2'd2;
        else if (st == 2'd2 && la[11:0] == 12'h555 && dq_i == 8'h90) begin
            st = 2'd0;
            idm = 1'b1;
        end else if (st == 2'd2 && la[11:0] == 12'h555 && dq_i == 8'ha0) st = 2'd3;
        else if (st == 2'd3) begin
            st = 2'd0;
            if (!PROT[la[16:14]]) begin
                pa = la;
                pd = dq_i;
                busy = 2'd3;
            end
        end else st = 2'd0;
    end
    // Each read while busy advances the embedded program
    always @(negedge oe_n_i) if (!ce_n_i && busy != 2'd0) begin
        tog = ~tog;
        busy = busy - 2'd1;
        if (busy == 2'd0) mem[pa[3:0]] = mem[pa[3:0]] & pd;
    end
endmodule // flash_dev_model

// [verif/testbench.sv]
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
`include "flash_ctrl_consts.vh"
module testbench;
    // ****************
    // Signals
    // ****************
    localparam [7:0] MAKER = 8'h3a; // Arbitrary value
    localparam [7:0] PART  = 8'h5c; // Arbitrary value
    localparam [7:0] CFG   = 8'h4b; // Arbitrary value
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         cyc = 1'b0;
    reg         stb = 1'b0;
    reg         we = 1'b0;
    reg  [3:0]  adr = 4'h0;
    reg  [31:0] dat = 32'h0000_0000;
    reg  [31:0] q;               // Last read data
    wire [31:0] rdat;
    wire        ack;
    wire [16:0] fa;
    wire [7:0]  fdo, fdi;
    wire        foe, ce_n, oe_n, we_n;
    integer     mismatches = 0;
    integer     n_tests = 0;

    always #10 clk_i = ~clk_i;

    flash_host_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .fl_addr_o(fa), .fl_dq_o(fdo), .fl_dq_oe_o(foe), .fl_dq_i(fdi),
        .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n));
    flash_dev_model #(.MAKER(MAKER), .PART(PART), .CFG(CFG)) dev (.addr_i(fa), .dq_i(fdo),
        .dq_oe_i(foe), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_o(fdi));

    // ****************
    // Tasks
    // ****************
    // Classic single cycle, held until ack is sampled
    task wb(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            @(posedge clk_i);
            while (ack !== 1'b1) @(posedge clk_i);
            q = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input string name);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // Start an operation and wait for busy to drop
    task op(input [2:0] c);
        begin
            wb(1'b1, `REG_CTRL, {29'h0000_0000, c});
            q = 32'h0000_0001;
            while (q[`ST_BUSY] !== 1'b0) wb(1'b0, `REG_STATUS, 32'h0000_0000);
        end
    endtask
    task setad(input [16:0] a, input [7:0] d);
        begin
            wb(1'b1, `REG_ADDR, {15'h0000, a});
            wb(1'b1, `REG_WDATA, {24'h00_0000, d});
        end
    endtask
    // One flash read, byte compared from status
    task fread(input [16:0] a, input [7:0] e, input string name);
        begin
            setad(a, 8'h00);
            op(`OP_READ);
            wb(1'b0, `REG_STATUS, 32'h0000_0000);
            check({24'h00_0000, q[15:8]}, {24'h00_0000, e}, name);
        end
    endtask
    // Program then poll; done must be set and timeout clear
    task prog(input [16:0] a, input [7:0] d);
        begin
            setad(a, d);
            op(`OP_PROGRAM);
            op(`OP_POLL);
            wb(1'b0, `REG_STATUS, 32'h0000_0000);
            check({29'h0000_0000, q[2:0]}, 32'h0000_0004, "poll status");
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `REG_STATUS, 32'h0000_0000);
        check(q, 32'h0000_0000, "status reset");
        wb(1'b0, 4'h2, 32'h0000_0000);
        check(q, 32'h0000_0000, "unmapped");
        fread(17'h0_0003, 8'ha3, "array");
        op(`OP_AUTOSEL);
        fread(17'h0_0100, MAKER, "maker");
        fread(17'h0_0000, CFG, "config");
        fread(17'h0_0001, PART, "part");
        fread(17'h1_c002, 8'h01, "protected");
        fread(17'h0_4002, 8'h00, "unprotected");
        op(`OP_RESET);
        fread(17'h0_0001, 8'ha1, "array after exit");
        prog(17'h0_0003, 8'h12);
        fread(17'h0_0003, 8'ha3 & 8'h12, "programmed");
        prog(17'h1_c005, 8'h00);
        fread(17'h1_c005, 8'ha5, "protected byte");
        setad(17'h0_0555, 8'haa);
        op(`OP_WRITE);
        setad(17'h0_0123, 8'h55);
        op(`OP_WRITE);
        setad(17'h0_0555, 8'h90);
        op(`OP_WRITE);
        fread(17'h0_0100, 8'ha0, "bad sequence");
        end_sim;
    end
    // Watchdog against a hung handshake
    initial begin
        #1_000_000;
        mismatches = mismatches + 1;
        end_sim;
    end
endmodule // testbench
